/* logic/ptpts_pkg.sv */
// Package: constants and carriers for the time keeping and fire stamping block
package ptpts_pkg;
  // Clock and time base
  localparam int CLK_MHZ          = 100;
  localparam int US_PER_SEC       = 1000000;
  localparam int CYC_PER_US       = CLK_MHZ;
  localparam int SEC_W            = 32;
  localparam int US_W             = 20;
  localparam int TNS_W            = 48;
  // Virtual origin 2000-01-01 00:00:00 as seconds since 1970
  localparam logic [SEC_W-1:0] ORIGIN_SEC = 32'h386D4380;
  // Block timing in units of 10 ns
  localparam int N_BLOCKS         = 10;
  localparam int N_CHANNELS       = 40;
  localparam int N_SLOTS          = 32;
  localparam logic [TNS_W-1:0] BLK10_END_CT = 48'h000000000B2A; // 28.58 us
  localparam logic [TNS_W-1:0] BLK_STEP_CT  = 48'h0000000015B4; // 55.56 us
  // Sync states
  typedef enum logic [1:0] {
    PTPTS_FREE_RUN = 2'b00,
    PTPTS_TRACKING = 2'b01,
    PTPTS_LOCKED   = 2'b10,
    PTPTS_FROZEN   = 2'b11
  } ptpts_sync_e;
  // Time value carried between master, counter and packet
  typedef struct packed {
    logic [SEC_W-1:0] sec;
    logic [US_W-1:0]  microsecond_part;
  } ptpts_time_s;
  // Firing offset per channel, in 10 ns units magnitude (negative offset)
  function automatic logic [12:0] ptpts_fire_off(input logic [5:0] ch);
    case (ch)
      6'd8:  ptpts_fire_off = 13'h155B; 6'd20: ptpts_fire_off = 13'h1496;
      6'd15: ptpts_fire_off = 13'h13D1; 6'd27: ptpts_fire_off = 13'h130C;
      6'd7:  ptpts_fire_off = 13'h128A; 6'd19: ptpts_fire_off = 13'h11C5;
      6'd5:  ptpts_fire_off = 13'h11C5; 6'd33: ptpts_fire_off = 13'h1100;
      6'd37: ptpts_fire_off = 13'h107E; 6'd1:  ptpts_fire_off = 13'h107E;
      6'd11: ptpts_fire_off = 13'h0FFB; 6'd23: ptpts_fire_off = 13'h0F37;
      6'd18: ptpts_fire_off = 13'h0E72; 6'd30: ptpts_fire_off = 13'h0DAD;
      6'd10: ptpts_fire_off = 13'h0D2B; 6'd22: ptpts_fire_off = 13'h0C66;
      6'd6:  ptpts_fire_off = 13'h0C66; 6'd34: ptpts_fire_off = 13'h0BA1;
      6'd38: ptpts_fire_off = 13'h0B1F; 6'd2:  ptpts_fire_off = 13'h0B1F;
      6'd14: ptpts_fire_off = 13'h0A9C; 6'd26: ptpts_fire_off = 13'h09D7;
      6'd21: ptpts_fire_off = 13'h0955; 6'd31: ptpts_fire_off = 13'h0890;
      6'd13: ptpts_fire_off = 13'h080E; 6'd9:  ptpts_fire_off = 13'h080E;
      6'd25: ptpts_fire_off = 13'h0749; 6'd35: ptpts_fire_off = 13'h06C7;
      6'd39: ptpts_fire_off = 13'h0644; 6'd3:  ptpts_fire_off = 13'h0644;
      6'd17: ptpts_fire_off = 13'h05C2; 6'd29: ptpts_fire_off = 13'h04FD;
      6'd24: ptpts_fire_off = 13'h047B; 6'd32: ptpts_fire_off = 13'h03B6;
      6'd16: ptpts_fire_off = 13'h0333; 6'd12: ptpts_fire_off = 13'h0333;
      6'd28: ptpts_fire_off = 13'h026F; 6'd36: ptpts_fire_off = 13'h01EC;
      6'd40: ptpts_fire_off = 13'h016A; 6'd4:  ptpts_fire_off = 13'h016A;
      default: ptpts_fire_off = 13'h0000;
    endcase
  endfunction : ptpts_fire_off
endpackage : ptpts_pkg

/* logic/ptpts_fire_calc.sv */
// Fire time calculator: block end time and channel firing instant
`timescale 1ns/100ps
module ptpts_fire_calc (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic                          ce,
  // Query
  input  wire logic [ptpts_pkg::TNS_W-1:0]   pkt_time_ct,
  input  wire logic                          dual_return,
  input  wire logic [3:0]                    block_num,
  input  wire logic [5:0]                    chan_num,
  // Results in 10 ns units
  output logic      [ptpts_pkg::TNS_W-1:0]   block_end_ct,
  output logic      [ptpts_pkg::TNS_W-1:0]   fire_ct
);
  // Multiple of the block period for a step count
  function automatic logic [ptpts_pkg::TNS_W-1:0] step_mul(input logic [3:0] s);
    step_mul = ptpts_pkg::TNS_W'(ptpts_pkg::BLK_STEP_CT * s);
  endfunction : step_mul

  // Step count: single uses 10-N, dual uses pair index
  wire logic [3:0] single_steps = 4'(4'd10 - block_num);
  wire logic [3:0] dual_steps   = 4'((4'd10 - block_num) >> 1);
  wire logic [3:0] steps        = dual_return ? dual_steps : single_steps;
  wire logic [ptpts_pkg::TNS_W-1:0] back_ct =
    ptpts_pkg::BLK10_END_CT + step_mul(steps);
  wire logic [ptpts_pkg::TNS_W-1:0] end_now = pkt_time_ct - back_ct;
  wire logic [ptpts_pkg::TNS_W-1:0] fire_now =
    end_now - {35'h0, ptpts_pkg::ptpts_fire_off(chan_num)};

  // Registered results
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      block_end_ct <= '0;
      fire_ct      <= '0;
    end else if (ce) begin
      block_end_ct <= end_now;
      fire_ct      <= fire_now;
    end
  end
endmodule : ptpts_fire_calc

/* logic/ptpts_top.sv */
// Top: precision time slave clock, packet stamping and fire time derivation
// Functional notes
// - With the network time source selected the block is only a time slave of the master, needing no setup.
// - With the network time source selected the per-second satellite packet request is held off.
// - In free run time starts at 2000-01-01 00:00:00 and advances on the internal one-second pulse.
// - With the network time source selected, in tracking or locked state time with microsecond resolution is loaded from master messages.
// - In frozen state counting continues from the last synchronized value on the internal pulse.
// - Packet date/time and timestamp equal the master time with no local offset.
// - Packet absolute time is the whole seconds plus the microsecond part.
// - Single return: block 10 ends 28.58 us before packet time, block N a further 55.56 us times (10-N).
// - Dual return: block pairs share an end time stepped back 55.56 us per pair.
// - A channel fires at its block end time plus a fixed negative per-channel offset.
// - Channels fire in 32 slots, channel 8 first at -54.67 us, channels 40 and 4 last at -3.62 us.
`timescale 1ns/100ps
module ptpts_top (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic                          ce,
  // Source selection and sync state
  input  wire logic                          ptp_selected,
  input  wire ptpts_pkg::ptpts_sync_e        sync_state,
  // Master time messages
  input  wire logic                          master_valid,
  input  wire ptpts_pkg::ptpts_time_s        master_time,
  // Packet stamping request
  input  wire logic                          pkt_stamp,
  input  wire logic                          dual_return,
  input  wire logic [3:0]                    block_num,
  input  wire logic [5:0]                    chan_num,
  // Time outputs
  output ptpts_pkg::ptpts_time_s             cur_time,
  output ptpts_pkg::ptpts_time_s             pkt_time,
  output logic                               one_pps,
  output logic                               gps_pkt_req,
  output logic      [ptpts_pkg::TNS_W-1:0]   packet_abs_time,
  output logic      [ptpts_pkg::TNS_W-1:0]   block_end_ct,
  output logic      [ptpts_pkg::TNS_W-1:0]   fire_ct
);
  localparam logic [6:0]  CYC_LAST = 7'(ptpts_pkg::CYC_PER_US - 1);
  localparam logic [19:0] US_LAST  = 20'(ptpts_pkg::US_PER_SEC - 1);

  logic [6:0] cyc;
  logic [6:0] next_cyc;
  ptpts_pkg::ptpts_time_s next_time;
  logic       next_pps;

  // Sync state decode
  wire logic sync_now = ptp_selected &&
    (sync_state == ptpts_pkg::PTPTS_TRACKING || sync_state == ptpts_pkg::PTPTS_LOCKED);
  wire logic us_tick  = cyc == CYC_LAST;
  wire logic sec_tick = us_tick && cur_time.microsecond_part == US_LAST;

  // Next time: load from master, else count locally
  always_comb begin
    next_cyc  = us_tick ? 7'h00 : 7'(cyc + 7'h01);
    next_time = cur_time;
    next_pps  = 1'b0;
    if (sync_now && master_valid) begin
      next_time = master_time;
      next_cyc  = 7'h00;
    end else if (sec_tick) begin
      next_time.microsecond_part = '0;
      next_time.sec = 32'(cur_time.sec + 32'h1);
      next_pps = 1'b1;
    end else if (us_tick) begin
      next_time.microsecond_part = 20'(cur_time.microsecond_part + 20'h1);
    end
  end

  // Time counter; reset seeds the virtual origin once, in any sync state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc      <= '0;
      cur_time <= '{sec: ptpts_pkg::ORIGIN_SEC, microsecond_part: 20'h0};
      one_pps  <= 1'b0;
    end else if (ce) begin
      cyc      <= next_cyc;
      cur_time <= next_time;
      one_pps  <= next_pps;
    end
  end

  // Satellite packet request on pulse, suppressed in network mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gps_pkt_req <= 1'b0;
    end else if (ce) begin
      gps_pkt_req <= next_pps && !ptp_selected;
    end
  end

  // Packet stamp: sum of seconds and microseconds in 10 ns units
  wire logic [ptpts_pkg::TNS_W-1:0] abs_now =
    ptpts_pkg::TNS_W'(cur_time.sec) * ptpts_pkg::TNS_W'(ptpts_pkg::US_PER_SEC * ptpts_pkg::CYC_PER_US)
    + ptpts_pkg::TNS_W'(cur_time.microsecond_part) * ptpts_pkg::TNS_W'(ptpts_pkg::CYC_PER_US);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pkt_time        <= '0;
      packet_abs_time <= '0;
    end else if (ce && pkt_stamp) begin
      pkt_time        <= cur_time;
      packet_abs_time <= abs_now;
    end
  end

  // Block end and firing instant from the stamped time
  ptpts_fire_calc u_fire (
    .clk          (clk),
    .rst_b        (rst_b),
    .ce           (ce),
    .pkt_time_ct  (packet_abs_time),
    .dual_return  (dual_return),
    .block_num    (block_num),
    .chan_num     (chan_num),
    .block_end_ct (block_end_ct),
    .fire_ct      (fire_ct)
  );
endmodule : ptpts_top

/* sim/ptpts_assertions.sv */
// Checker: time keeping and fire time relations at the top ports
`timescale 1ns/100ps
module ptpts_assertions (
  // Clock, reset and inputs
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic                   ce,
  input wire logic                   ptp_selected,
  input wire ptpts_pkg::ptpts_sync_e sync_state,
  input wire logic                   master_valid,
  input wire ptpts_pkg::ptpts_time_s master_time,
  input wire logic                   pkt_stamp,
  input wire logic                   dual_return,
  input wire logic [3:0]             block_num,
  input wire logic [5:0]             chan_num,
  // Outputs
  input wire ptpts_pkg::ptpts_time_s cur_time,
  input wire ptpts_pkg::ptpts_time_s pkt_time,
  input wire logic                   one_pps,
  input wire logic                   gps_pkt_req,
  input wire logic [47:0]            packet_abs_time,
  input wire logic [47:0]            block_end_ct,
  input wire logic [47:0]            fire_ct
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Master load, block steps and expected end time
  wire        ld   = ce && master_valid && ptp_selected && (sync_state == 2'b01 || sync_state == 2'b10);
  wire [31:0] sec  = cur_time.sec;
  wire [3:0]  k    = dual_return ? (4'hA - block_num) >> 1 : 4'hA - block_num;
  wire [47:0] bexp = packet_abs_time - 48'hB2A - 48'h15B4 * k;
  a_gps_off: assert property (ptp_selected && $past(ptp_selected) |-> !gps_pkt_req)
    else $error("satellite packet request while network time selected");
  a_master_load: assert property (ld |=> cur_time == $past(master_time))
    else $error("master time not loaded");
  a_load_refused: assert property (ce && master_valid && !ld |=> sec - $past(sec) <= 32'h1)
    else $error("master time taken in a local state");
  a_stamp_copy: assert property (ce && pkt_stamp |=> pkt_time == $past(cur_time))
    else $error("stamped time differs");
  a_abs_time: assert property (ce && pkt_stamp |=>
    packet_abs_time == {16'h0, pkt_time.sec} * 48'h5F5E100 + {28'h0, pkt_time.microsecond_part} * 48'h64)
    else $error("packet time sum wrong");
  a_pps_wrap: assert property (one_pps && !$past(ld) |->
    cur_time.microsecond_part == 20'h0 && sec == $past(sec) + 32'h1) else $error("second carry wrong");
  a_block_end: assert property ($past(rst_b) && $past(ce) && $stable({packet_abs_time, dual_return, block_num})
    && block_num inside {[1:10]} |-> block_end_ct == bexp) else $error("block end time wrong");
  a_fire_off: assert property ($past(rst_b) && $past(ce) && $stable({packet_abs_time, block_num, chan_num})
    && $stable(dual_return) && block_num inside {[1:10]} && chan_num inside {6'h04, 6'h08, 6'h28}
    |-> fire_ct == bexp - (chan_num == 6'h08 ? 48'h155B : 48'h16A)) else $error("fire time wrong");
endmodule : ptpts_assertions
bind ptpts_top ptpts_assertions u_chk (
  .clk             (clk),
  .rst_b           (rst_b),
  .ce              (ce),
  .ptp_selected    (ptp_selected),
  .sync_state      (sync_state),
  .master_valid    (master_valid),
  .master_time     (master_time),
  .pkt_stamp       (pkt_stamp),
  .dual_return     (dual_return),
  .block_num       (block_num),
  .chan_num        (chan_num),
  .cur_time        (cur_time),
  .pkt_time        (pkt_time),
  .one_pps         (one_pps),
  .gps_pkt_req     (gps_pkt_req),
  .packet_abs_time (packet_abs_time),
  .block_end_ct    (block_end_ct),
  .fire_ct         (fire_ct)
);

/* sim/ptpts_master_model.sv */
// Partner: network time master sending one timing message per request
`timescale 1ns/100ps
module ptpts_master_model (
  // Clock and command
  input  wire logic                   clk,
  input  wire logic                   send,
  input  wire ptpts_pkg::ptpts_time_s t_in,
  // Message to the slave
  output ptpts_pkg::ptpts_time_s      master_time,
  output logic                        master_valid
);
  initial master_valid = 1'b0;
  initial master_time = '0;
  // One cycle message, time field scrambled between messages
  always @(negedge clk) begin
    master_valid <= send;
    master_time  <= send ? t_in : ~master_time;
  end
endmodule : ptpts_master_model

/* sim/tb_ptpts_top.sv */
// Testbench: time keeping, stamping, block and fire times
`timescale 1ns/100ps
module tb_ptpts_top;
  logic                   clk = 1'b0, rst_b = 1'b0, sel = 1'b1, stamp = 1'b0, dual = 1'b0, send = 1'b0;
  logic                   mv, pps, req;
  logic [3:0]             blk = 4'hA;
  logic [5:0]             ch = 6'h08;
  logic [47:0]            abs_t, bend, fire, e;
  ptpts_pkg::ptpts_sync_e st = ptpts_pkg::PTPTS_FREE_RUN;
  ptpts_pkg::ptpts_time_s t_in = '0, mt, cur, pkt;
  int                     fails = 0, n_checks = 0, n_pps = 0, n_req = 0;
  always #5 clk = ~clk;
  // Count second pulses and satellite packet requests
  always @(posedge clk) begin
    n_pps <= n_pps + int'(pps);
    n_req <= n_req + int'(req);
  end
  ptpts_master_model u_master (.clk(clk), .send(send), .t_in(t_in), .master_time(mt), .master_valid(mv));
  ptpts_top u_dut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .ptp_selected(sel), .sync_state(st), .master_valid(mv),
    .master_time(mt), .pkt_stamp(stamp), .dual_return(dual), .block_num(blk), .chan_num(ch), .cur_time(cur),
    .pkt_time(pkt), .one_pps(pps), .gps_pkt_req(req), .packet_abs_time(abs_t), .block_end_ct(bend), .fire_ct(fire));
  task automatic chk(input logic [51:0] got, input logic [51:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic load(input logic [31:0] s, input logic [19:0] us);
    @(negedge clk) send <= 1'b1;
    t_in <= '{s, us};
    @(negedge clk) send <= 1'b0;
    @(negedge clk);
  endtask : load
  // Origin after reset, master ignored in free run, then load and stamp
  task automatic t_stamp;
    chk(cur, {ptpts_pkg::ORIGIN_SEC, 20'h0});
    load(32'h12345678, 20'h00010);
    chk(cur.sec, ptpts_pkg::ORIGIN_SEC);
    st <= ptpts_pkg::PTPTS_LOCKED;
    load(32'h00001000, 20'h00123);
    chk(cur, {32'h00001000, 20'h00123});
    stamp <= 1'b1;
    @(negedge clk) stamp <= 1'b0;
    chk(pkt, {32'h00001000, 20'h00123});
    chk(abs_t, 48'h1000 * 48'h5F5E100 + 48'h123 * 48'h64);
    st <= ptpts_pkg::PTPTS_TRACKING;
    load(32'h00001001, 20'h00456);
    chk(cur, {32'h00001001, 20'h00456});
  endtask : t_stamp
  // Every block in both modes, channels 8, 40 and 4
  task automatic t_blocks;
    for (int m = 0; m < 20; m++) begin
      @(negedge clk) dual <= m >= 10;
      blk <= 4'(m % 10 + 1);
      ch <= m % 3 == 0 ? 6'h08 : (m % 3 == 1 ? 6'h28 : 6'h04);
      repeat (2) @(negedge clk);
      e = abs_t - 48'hB2A - 48'h15B4 * (dual ? (10 - blk) / 2 : 10 - blk);
      chk(bend, e);
      chk(fire, e - (ch == 6'h08 ? 48'h155B : 48'h16A));
    end
  endtask : t_blocks
  // Load near a second end, freeze, and watch the carry
  task automatic t_wrap(input logic s);
    int p0, r0;
    sel <= 1'b1;
    st <= ptpts_pkg::PTPTS_LOCKED;
    load(32'h00002000, 20'hF4236);
    p0 = n_pps;
    r0 = n_req;
    st <= ptpts_pkg::PTPTS_FROZEN;
    sel <= s;
    load(32'h00005000, 20'h00000);
    repeat (1200) @(negedge clk);
    chk(cur.sec, 32'h00002001);
    chk(n_pps - p0, 1);
    chk(n_req - r0, s ? 0 : 1);
  endtask : t_wrap
  initial begin
    repeat (10) @(negedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    t_stamp;
    t_blocks;
    t_wrap(1'b1);
    t_wrap(1'b0);
    finish_test;
  end
  initial begin
    #100000;
    fails++;
    finish_test;
  end
endmodule : tb_ptpts_top
